// >>> core/vrd_decoder.sv
// vector remap address decoder for the core's fetch and data bus
`timescale 1ns/1ps
module vrd_decoder #(
    parameter vrd_pkg::vrd_size_e FLASH_SZ = vrd_pkg::SZ_LARGE,
    parameter vrd_pkg::vrd_size_e SRAM_SZ = vrd_pkg::SZ_LARGE
) (
    // clock, reset, enable
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,

    // core request
    input wire logic REQ_VALID_I,
    input wire logic [31:0] REQ_ADDR_I,
    input wire logic REQ_FETCH_I,
    input wire logic REQ_WRITE_I,

    // mapping mode control
    input wire logic MAP_WE_I,
    input wire logic [1:0] MAP_MODE_I,

    // decoded access towards the memories
    output logic RESP_VALID_O,
    output vrd_pkg::vrd_tgt_e SEL_TGT_O,
    output logic [31:0] MEM_ADDR_O,
    output logic MEM_WRITE_O,

    // abort indications to the core
    output logic PABORT_O,
    output logic DABORT_O,

    // vector status
    output logic VEC_HIT_O,
    output logic [2:0] VEC_IDX_O,
    output logic VEC_KEY_O,
    output logic REMAP_HIT_O,

    // current mapping mode
    output vrd_pkg::vrd_mode_e MAP_MODE_O
);
    import vrd_pkg::*;

    // ------------------------------------------------------------
    // mapping mode state
    // ------------------------------------------------------------
    vrd_mode_e mode_ff;
    vrd_mode_e nxt_mode;

    // code 2'b11 is not a mode, so a write of it is dropped
    wire logic mode_legal = (MAP_MODE_I != 2'b11);
    wire logic mode_wr = CE_I && MAP_WE_I && mode_legal;

    // boot firmware picks flash, a user program picks ram
    assign nxt_mode = mode_wr ? vrd_mode_e'(MAP_MODE_I) : mode_ff;

    // reset always returns to boot mapping
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mode_ff <= MODE_RST;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    // ------------------------------------------------------------
    // vector overlay
    // ------------------------------------------------------------
    // overlay covers the full 64 bytes, not just the vector words
    wire logic remap_win = (REQ_ADDR_I <= REMAP_LAST);
    wire logic [REMAP_BITS-1:0] remap_off = REQ_ADDR_I[REMAP_BITS-1:0];

    // vector words live at fixed word addresses from zero
    // compare words, so every byte of the last vector word still hits
    wire logic vec_win = (REQ_ADDR_I[31:VEC_IDX_LSB] <= VEC_LAST[31:VEC_IDX_LSB]);
    wire logic [2:0] vec_idx = REQ_ADDR_I[VEC_IDX_LSB+2:VEC_IDX_LSB];

    // the reserved word doubles as the user program key
    wire logic key_hit = (REQ_ADDR_I[31:VEC_IDX_LSB] == VEC_KEY[31:VEC_IDX_LSB]);

    wire logic [31:0] boot_alias = BOOT_BASE | {26'h0, remap_off};
    wire logic [31:0] sram_alias = SRAM_BASE | {26'h0, remap_off};

    // flash mode passes the address through untouched
    // ram mode points the low window at the bottom of sram
    // boot mode points it at the bottom of the boot block
    logic [31:0] eff_addr;
    always_comb begin
        eff_addr = REQ_ADDR_I;
        if (remap_win) begin
            unique case (mode_ff)
                MODE_BOOT: eff_addr = boot_alias;
                MODE_RAM: eff_addr = sram_alias;
                MODE_FLASH: eff_addr = REQ_ADDR_I;
            endcase
        end
    end
    // native addresses bypass the overlay, so both reach one store
    // outside the window the address is never touched

    // ------------------------------------------------------------
    // region classification
    // ------------------------------------------------------------
    vrd_tgt_e reg_tgt;
    logic reg_periph;

    vrd_region #(
        .FLASH_SZ(FLASH_SZ),
        .SRAM_SZ(SRAM_SZ)
    ) u_region (
        .addr_i(eff_addr),
        .tgt_o(reg_tgt),
        .periph_o(reg_periph)
    );

    // ------------------------------------------------------------
    // abort generation
    // ------------------------------------------------------------
    wire logic take = CE_I && REQ_VALID_I;
    // unmapped space faults whichever way it is reached
    wire logic unmapped = (reg_tgt == TGT_NONE);
    // code never runs from peripheral space
    wire logic fetch_periph = REQ_FETCH_I && reg_periph;
    // fetch faults and data faults stay apart
    wire logic nxt_pabort = take && REQ_FETCH_I && (unmapped || fetch_periph);
    wire logic nxt_dabort = take && !REQ_FETCH_I && unmapped;
    // a faulted access must not reach any memory
    wire logic faulted = nxt_pabort || nxt_dabort;
    wire vrd_tgt_e nxt_tgt = (take && !faulted) ? reg_tgt : TGT_NONE;
    wire logic nxt_write = take && !faulted && REQ_WRITE_I && !REQ_FETCH_I;

    // ------------------------------------------------------------
    // registered answer, one cycle after the request
    // ------------------------------------------------------------
    logic resp_valid_ff;
    vrd_tgt_e sel_tgt_ff;
    logic [31:0] mem_addr_ff;
    logic mem_write_ff;
    logic pabort_ff;
    logic dabort_ff;
    logic vec_hit_ff;
    logic [2:0] vec_idx_ff;
    logic vec_key_ff;
    logic remap_hit_ff;

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            resp_valid_ff <= 1'b0;
            sel_tgt_ff <= TGT_NONE;
            mem_write_ff <= 1'b0;
            pabort_ff <= 1'b0;
            dabort_ff <= 1'b0;
        end else if (CE_I) begin
            resp_valid_ff <= REQ_VALID_I;
            sel_tgt_ff <= nxt_tgt;
            mem_write_ff <= nxt_write;
            pabort_ff <= nxt_pabort;
            dabort_ff <= nxt_dabort;
        end
    end

    // address and vector status only hold meaning with a request
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            mem_addr_ff <= 32'h0000_0000;
            vec_hit_ff <= 1'b0;
            vec_idx_ff <= 3'h0;
            vec_key_ff <= 1'b0;
            remap_hit_ff <= 1'b0;
        end else if (CE_I) begin
            mem_addr_ff <= take ? eff_addr : 32'h0000_0000;
            vec_hit_ff <= take && vec_win;
            vec_idx_ff <= (take && vec_win) ? vec_idx : 3'h0;
            vec_key_ff <= take && key_hit;
            remap_hit_ff <= take && remap_win && (mode_ff != MODE_FLASH);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign RESP_VALID_O = resp_valid_ff;
    assign SEL_TGT_O = sel_tgt_ff;
    assign MEM_ADDR_O = mem_addr_ff;
    assign MEM_WRITE_O = mem_write_ff;
    assign PABORT_O = pabort_ff;
    assign DABORT_O = dabort_ff;
    assign VEC_HIT_O = vec_hit_ff;
    assign VEC_IDX_O = vec_idx_ff;
    assign VEC_KEY_O = vec_key_ff;
    assign REMAP_HIT_O = remap_hit_ff;
    assign MAP_MODE_O = mode_ff;

endmodule

// >>> core/vrd_pkg.sv
// constants, types and helper functions of the vector remap address decoder
//
// Overview of operation
// - The eight exception vectors sit at fixed words 0x0 to 0x1c, from reset up to fiq.
// - The reserved vector word at 0x14 is flagged as the valid-user-program key location.
// - Any reset puts the decoder into boot-loader mapping with boot vectors at address zero.
// - Boot firmware selects user-flash mapping, where the vectors come unchanged from flash.
// - A user program may select user-ram mapping, serving the vectors from the bottom of sram.
// - The overlay spans 64 bytes, addresses 0x00 to 0x3f, in every remapped mode.
// - Overlaid memory stays reachable at its native address as well as at address zero.
// - The boot block sits at the top of on-chip memory space whatever the flash size.
// - Except for the overlay, every region decodes at the same address in all modes.
// - Any access to a reserved or unassigned region ends in the matching bus abort.
// - From the end of flash up to 0x3fffffff every access aborts.
// - From the end of sram up to 0x7fffdfff every access aborts.
// - An instruction fetch anywhere in either peripheral space gets a prefetch abort.
// - Undefined offsets inside an existing peripheral do not abort and may alias.
package vrd_pkg;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_BOOT  = 2'b00,
        MODE_FLASH = 2'b01,
        MODE_RAM   = 2'b10
    } vrd_mode_e;

    typedef enum logic [1:0] {
        SZ_SMALL = 2'b00,
        SZ_MID   = 2'b01,
        SZ_LARGE = 2'b10
    } vrd_size_e;

    typedef enum logic [2:0] {
        TGT_NONE  = 3'b000,
        TGT_FLASH = 3'b001,
        TGT_SRAM  = 3'b010,
        TGT_BOOT  = 3'b011,
        TGT_APB   = 3'b100,
        TGT_AHB   = 3'b101
    } vrd_tgt_e;

    // ------------------------------------------------------------
    // vector words and overlay
    // ------------------------------------------------------------
    localparam logic [31:0] VEC_RESET = 32'h0000_0000;
    localparam logic [31:0] VEC_KEY = 32'h0000_0014;
    localparam logic [31:0] VEC_LAST = 32'h0000_001c;
    localparam logic [31:0] REMAP_LAST = 32'h0000_003f;
    localparam int REMAP_BITS = 6;
    localparam int VEC_IDX_LSB = 2;
    localparam vrd_mode_e MODE_RST = MODE_BOOT;

    // ------------------------------------------------------------
    // memory regions
    // ------------------------------------------------------------
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] FLASH_END_SMALL = 32'h0000_2000;
    localparam logic [31:0] FLASH_END_MID = 32'h0000_4000;
    localparam logic [31:0] FLASH_END_LARGE = 32'h0000_8000;
    localparam logic [31:0] SRAM_BASE = 32'h4000_0000;
    localparam logic [31:0] SRAM_END_SMALL = 32'h4000_0800;
    localparam logic [31:0] SRAM_END_MID = 32'h4000_1000;
    localparam logic [31:0] SRAM_END_LARGE = 32'h4000_2000;
    localparam logic [31:0] BOOT_BASE = 32'h7fff_e000;
    localparam logic [31:0] BOOT_LAST = 32'h7fff_ffff;
    localparam logic [31:0] APB_BASE = 32'he000_0000;
    localparam logic [31:0] APB_LAST = 32'he01f_ffff;
    localparam logic [31:0] AHB_BASE = 32'hffe0_0000;
    localparam logic [31:0] AHB_LAST = 32'hffff_ffff;

    // ------------------------------------------------------------
    // peripheral slots, 16 kB each, 128 per space
    // ------------------------------------------------------------
    localparam int SLOT_LSB = 14;
    localparam int SLOT_MSB = 20;
    localparam logic [127:0] APB_SLOT_USED = 128'h8000_0000_0000_0000_0000_0000_3c80_2f9f;
    localparam logic [127:0] AHB_SLOT_USED = 128'h8000_0000_0000_0000_0000_0000_0000_0000;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic in_span(input logic [31:0] a, input logic [31:0] lo,
                                     input logic [31:0] hi);
        in_span = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic [31:0] flash_end(input vrd_size_e sz);
        unique case (sz)
            SZ_SMALL: flash_end = FLASH_END_SMALL;
            SZ_MID: flash_end = FLASH_END_MID;
            default: flash_end = FLASH_END_LARGE;
        endcase
    endfunction

    function automatic logic [31:0] sram_end(input vrd_size_e sz);
        unique case (sz)
            SZ_SMALL: sram_end = SRAM_END_SMALL;
            SZ_MID: sram_end = SRAM_END_MID;
            default: sram_end = SRAM_END_LARGE;
        endcase
    endfunction

endpackage

// >>> core/vrd_region.sv
// region classifier: maps an effective address onto a memory target
`timescale 1ns/1ps
module vrd_region #(
    parameter vrd_pkg::vrd_size_e FLASH_SZ = vrd_pkg::SZ_LARGE,
    parameter vrd_pkg::vrd_size_e SRAM_SZ = vrd_pkg::SZ_LARGE
) (
    // address in
    input wire logic [31:0] addr_i,
    // classification out
    output vrd_pkg::vrd_tgt_e tgt_o,
    output logic periph_o
);
    import vrd_pkg::*;

    // ------------------------------------------------------------
    // window hits
    // ------------------------------------------------------------
    wire logic [31:0] fl_last = flash_end(FLASH_SZ) - 32'h0000_0001;
    wire logic [31:0] sr_last = sram_end(SRAM_SZ) - 32'h0000_0001;
    wire logic [6:0] slot = addr_i[SLOT_MSB:SLOT_LSB];
    // gap above flash falls out of every window
    wire logic fl_hit = in_span(addr_i, FLASH_BASE, fl_last);
    // gap above sram up to the boot block as well
    wire logic sr_hit = in_span(addr_i, SRAM_BASE, sr_last);
    // boot block pinned at the top, size independent
    wire logic bt_hit = in_span(addr_i, BOOT_BASE, BOOT_LAST);
    wire logic apb_win = in_span(addr_i, APB_BASE, APB_LAST);
    wire logic ahb_win = in_span(addr_i, AHB_BASE, AHB_LAST);
    // only the slot is decoded; offsets inside a slot alias freely
    wire logic apb_hit = apb_win && APB_SLOT_USED[slot];
    wire logic ahb_hit = ahb_win && AHB_SLOT_USED[slot];

    // ------------------------------------------------------------
    // target select
    // ------------------------------------------------------------
    // anything left over is reserved or unassigned
    assign tgt_o = fl_hit ? TGT_FLASH :
                   sr_hit ? TGT_SRAM :
                   bt_hit ? TGT_BOOT :
                   apb_hit ? TGT_APB :
                   ahb_hit ? TGT_AHB : TGT_NONE;
    assign periph_o = apb_win || ahb_win;

endmodule

// >>> testbench/vrd_core_model.sv
// core-side model: drives accesses and mode writes
`timescale 1ns/1ps
module vrd_core_model (
    // commands from the bench
    input wire logic go_i,
    input wire logic [31:0] addr_i,
    input wire logic fetch_i,
    input wire logic write_i,
    input wire logic mw_i,
    input wire logic [1:0] mm_i,
    // bus towards the decoder
    output logic req_valid_o,
    output logic [31:0] req_addr_o,
    output logic req_fetch_o,
    output logic req_write_o,
    output logic map_we_o,
    output logic [1:0] map_mode_o
);
    // idle bus shows inverted values so stale data never looks valid
    assign req_valid_o = go_i;
    assign req_addr_o = go_i ? addr_i : ~addr_i;
    assign req_fetch_o = go_i ? fetch_i : ~fetch_i;
    assign req_write_o = go_i ? write_i : ~write_i;
    // signature check is firmware's job, the model just writes
    assign map_we_o = mw_i;
    assign map_mode_o = mw_i ? mm_i : ~mm_i;
endmodule

// >>> testbench/vrd_decoder_properties.sv
// assertions on the ports of the vector remap decoder
`timescale 1ns/1ps
module vrd_decoder_properties #(
    parameter vrd_pkg::vrd_size_e FLASH_SZ = vrd_pkg::SZ_LARGE,
    parameter vrd_pkg::vrd_size_e SRAM_SZ = vrd_pkg::SZ_LARGE
) (
    // clock, reset, enable
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic CE_I,
    // request and mode write
    input wire logic REQ_VALID_I,
    input wire logic [31:0] REQ_ADDR_I,
    input wire logic REQ_FETCH_I,
    input wire logic MAP_WE_I,
    input wire logic [1:0] MAP_MODE_I,
    // answer
    input wire logic RESP_VALID_O,
    input wire vrd_pkg::vrd_tgt_e SEL_TGT_O,
    input wire logic [31:0] MEM_ADDR_O,
    input wire logic PABORT_O,
    input wire logic DABORT_O,
    input wire logic VEC_HIT_O,
    input wire logic [2:0] VEC_IDX_O,
    input wire logic VEC_KEY_O,
    input wire vrd_pkg::vrd_mode_e MAP_MODE_O
);
    import vrd_pkg::*;
    localparam logic [31:0] f_end = FLASH_SZ == SZ_SMALL ? FLASH_END_SMALL :
        FLASH_SZ == SZ_MID ? FLASH_END_MID : FLASH_END_LARGE;
    localparam logic [31:0] s_end = SRAM_SZ == SZ_SMALL ? SRAM_END_SMALL :
        SRAM_SZ == SZ_MID ? SRAM_END_MID : SRAM_END_LARGE;
    wire take = CE_I && REQ_VALID_I;
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_fetch_periph_abort: assert property (
        take && REQ_FETCH_I && REQ_ADDR_I >= APB_BASE |=> PABORT_O && !DABORT_O)
        else $error("fetch in peripheral space not aborted");
    a_flash_gap_abort: assert property (
        take && !REQ_FETCH_I && REQ_ADDR_I >= f_end && REQ_ADDR_I < SRAM_BASE
        |=> DABORT_O && SEL_TGT_O == TGT_NONE) else $error("flash gap not aborted");
    a_sram_gap_abort: assert property (
        take && REQ_ADDR_I >= s_end && REQ_ADDR_I < BOOT_BASE
        |=> PABORT_O != DABORT_O) else $error("sram gap not aborted");
    a_boot_fixed: assert property (
        take && REQ_ADDR_I >= BOOT_BASE && REQ_ADDR_I <= BOOT_LAST
        |=> SEL_TGT_O == TGT_BOOT && MEM_ADDR_O == $past(REQ_ADDR_I))
        else $error("boot block not at its fixed place");
    a_vec_index: assert property (
        take && REQ_ADDR_I < 32'h20 |=> VEC_HIT_O && VEC_IDX_O == $past(REQ_ADDR_I[4:2]))
        else $error("vector index wrong");
    a_key_word: assert property (
        $past(take) |-> VEC_KEY_O == ($past(REQ_ADDR_I[31:2]) == VEC_KEY[31:2]))
        else $error("key word flag wrong");
    a_mode_write: assert property (
        CE_I && MAP_WE_I && MAP_MODE_I != 2'b11 |=> MAP_MODE_O == $past(MAP_MODE_I))
        else $error("mode write not taken");
    a_ram_overlay: assert property (
        take && REQ_ADDR_I <= REMAP_LAST && MAP_MODE_O == MODE_RAM
        |=> SEL_TGT_O == TGT_SRAM && MEM_ADDR_O == SRAM_BASE + $past(REQ_ADDR_I))
        else $error("ram overlay wrong");
    a_reset_boot: assert property (
        disable iff (1'b0) !RSTN_I |-> MAP_MODE_O == MODE_BOOT && !RESP_VALID_O)
        else $error("reset did not select boot mapping");
    c_pabort: cover property (PABORT_O);
    c_dabort: cover property (DABORT_O);
    c_ram_map: cover property (VEC_HIT_O && MAP_MODE_O == MODE_RAM);
endmodule

// >>> testbench/vrd_decoder_tb.sv
// self-checking bench of the vector remap decoder
`timescale 1ns/1ps
module vrd_decoder_tb;
    import vrd_pkg::*;
    localparam vrd_size_e FLASH_SZ = SZ_LARGE;
    localparam vrd_size_e SRAM_SZ = SZ_LARGE;
    localparam logic [31:0] bases [12] = '{32'h0, 32'h7fc0, 32'h3fffffc0, 32'h40001fc0,
        32'h7fffdfc0, 32'h7fffffc0, 32'he0000000, 32'he0014000, 32'he01fc000,
        32'hdfffffc0, 32'hffdfffc0, 32'hffffc000};
    logic clk = 0, rstn = 1, ce, go, g_f, g_w, g_mw, rv, mw, pa, da, vh, vk, rh;
    logic rqv, rqf, rqw, we;
    logic [31:0] g_a, ma, rqa, seed = 32'd87663, r, r2;
    logic [1:0] g_mm, mm, mode_m;
    logic [2:0] vi;
    logic [44:0] pend;
    vrd_tgt_e tgt;
    vrd_mode_e mo;
    int n_errors = 0, comparisons = 0, cycles = 0, i;
    always #50 clk = ~clk;
    vrd_core_model vrd_core_model_i (.go_i(go), .addr_i(g_a), .fetch_i(g_f), .write_i(g_w),
        .mw_i(g_mw), .mm_i(g_mm), .req_valid_o(rqv), .req_addr_o(rqa), .req_fetch_o(rqf),
        .req_write_o(rqw), .map_we_o(we), .map_mode_o(mm));
    vrd_decoder #(.FLASH_SZ(FLASH_SZ), .SRAM_SZ(SRAM_SZ)) vrd_decoder_i (.CORE_CLK_I(clk),
        .RSTN_I(rstn), .CE_I(ce), .REQ_VALID_I(rqv), .REQ_ADDR_I(rqa), .REQ_FETCH_I(rqf),
        .REQ_WRITE_I(rqw), .MAP_WE_I(we), .MAP_MODE_I(mm), .RESP_VALID_O(rv), .SEL_TGT_O(tgt),
        .MEM_ADDR_O(ma), .MEM_WRITE_O(mw), .PABORT_O(pa), .DABORT_O(da), .VEC_HIT_O(vh),
        .VEC_IDX_O(vi), .VEC_KEY_O(vk), .REMAP_HIT_O(rh), .MAP_MODE_O(mo));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [44:0] expect_of(logic [31:0] a, logic f, logic w, logic [1:0] m);
        logic [31:0] e;
        logic [2:0] t;
        logic ab;
        e = a;
        if (a <= 32'h3f && m != 2'b01) e = (m == 2'b00 ? BOOT_BASE : SRAM_BASE) + a;
        t = TGT_NONE;
        if (e < FLASH_END_LARGE) t = TGT_FLASH;
        else if (e >= SRAM_BASE && e < SRAM_END_LARGE) t = TGT_SRAM;
        else if (e >= BOOT_BASE && e <= BOOT_LAST) t = TGT_BOOT;
        else if (e >= APB_BASE && e <= APB_LAST && APB_SLOT_USED[e[20:14]]) t = TGT_APB;
        else if (e >= AHB_BASE && AHB_SLOT_USED[e[20:14]]) t = TGT_AHB;
        if (f && e >= APB_BASE) t = TGT_NONE;
        ab = t == TGT_NONE;
        return {1'b1, t, ab & f, ab & !f, w & !f & !ab, a < 32'h20, a < 32'h20 ? a[4:2] : 3'h0,
            a[31:2] == 30'h5, a <= 32'h3f && m != 2'b01, e};
    endfunction
    task check(input string name, input logic [44:0] seen, input logic [44:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // checks the previous answer, then drives the next request
    task step(input logic v, input logic [31:0] a, input logic f, input logic w,
              input logic wm, input logic [1:0] m, input logic c);
        logic [44:0] s;
        @(negedge clk);
        s = {rv, tgt, pa, da, mw, vh, vi, vk, rh, ma};
        check("answer", s, pend);
        check("mode", {43'h0, mo}, {43'h0, mode_m});
        {go, g_a, g_f, g_w, g_mw, g_mm, ce} = {v, a, f, w, wm, m, c};
        if (c) begin
            pend = v ? expect_of(a, f, w, mode_m) : 45'h0;
            if (wm && m != 2'b11) mode_m = m;
        end
    endtask
    task end_of_test();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ------------------------------------------------------------
    // timeout and main sequence
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        // late start, so the reset flops always see a clean falling edge
        #10;
        {rstn, ce, go, g_a, g_f, g_w, g_mw, g_mm, pend, mode_m} = '0;
        repeat (3) @(posedge clk);
        @(negedge clk) rstn = 1;
        for (i = 0; i < 16; i++) step(1, i * 4, i[0], 0, 0, 0, 1);
        step(1, 32'h7fffe010, 0, 1, 0, 0, 1);
        step(1, 32'h8000, 0, 0, 0, 0, 1);
        step(1, 32'h7ffc, 1, 0, 0, 0, 1);
        step(1, 32'h40002000, 0, 0, 0, 0, 1);
        step(1, 32'h7fffdffc, 1, 0, 0, 0, 1);
        step(1, 32'he000d000, 0, 1, 0, 0, 1);
        step(1, 32'he0014000, 0, 0, 0, 0, 1);
        step(1, 32'he0000000, 1, 0, 0, 0, 1);
        step(1, 32'hffffc000, 1, 0, 0, 0, 1);
        step(1, 32'h80000000, 1, 0, 1, 2'b11, 1);
        step(1, 32'h10, 0, 1, 1, 2'b10, 1);
        step(1, 32'h3c, 0, 1, 0, 0, 1);
        step(1, 32'h40, 0, 0, 0, 0, 1);
        step(1, 32'h40000010, 0, 1, 1, 2'b01, 1);
        step(1, 32'h4, 1, 0, 1, 2'b00, 0);
        step(1, 32'h1c, 1, 0, 0, 0, 1);
        for (i = 0; i < 1500; i++) begin
            r = rnd();
            r2 = rnd();
            if (!r[3]) r2 = bases[r[7:4] % 12] + {25'h0, r2[6:0]};
            step(r[0], r2, r[1], r[2], r[11:9] == 0, r[13:12], r[16:14] != 0);
        end
        step(0, 0, 0, 0, 1, 2'b10, 1);
        // ram mode is seen before reset, so the return to boot means something
        step(0, 0, 0, 0, 0, 0, 1);
        {rstn, mode_m} = '0;
        @(negedge clk) rstn = 1;
        step(1, 32'h0, 1, 0, 0, 0, 1);
        step(0, 0, 0, 0, 0, 0, 1);
        end_of_test();
    end
endmodule
bind vrd_decoder vrd_decoder_properties #(.FLASH_SZ(FLASH_SZ), .SRAM_SZ(SRAM_SZ))
    vrd_decoder_properties_i (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I),
    .REQ_VALID_I(REQ_VALID_I), .REQ_ADDR_I(REQ_ADDR_I), .REQ_FETCH_I(REQ_FETCH_I),
    .MAP_WE_I(MAP_WE_I), .MAP_MODE_I(MAP_MODE_I), .RESP_VALID_O(RESP_VALID_O),
    .SEL_TGT_O(SEL_TGT_O), .MEM_ADDR_O(MEM_ADDR_O), .PABORT_O(PABORT_O), .DABORT_O(DABORT_O),
    .VEC_HIT_O(VEC_HIT_O), .VEC_IDX_O(VEC_IDX_O), .VEC_KEY_O(VEC_KEY_O),
    .MAP_MODE_O(MAP_MODE_O));
